/* File: src/fiber_regs_defines.svh */
// constants for the fiber event and pattern test register block
// assumes word-indexed registers, byte address is four times the index
`ifndef FIBER_REGS_DEFINES_SVH
`define FIBER_REGS_DEFINES_SVH

// register indices
`define IDX_ENABLE   6'h12
`define IDX_FLAGS    6'h13
`define IDX_TEST     6'h17
`define IDX_CNT_LO   6'h18
`define IDX_CNT_HI   6'h19
`define IDX_CTRL2    6'h1A
`define IDX_SOFT     6'h1F

// event flag positions
`define FLAG_SPEED   14
`define FLAG_DUPLEX  13
`define FLAG_PAGE    12
`define FLAG_AN      11
`define FLAG_LINK    10
`define FLAG_SYMBOL  9
`define FLAG_FALSE   8
`define FLAG_FIFO    7
`define FLAG_FAULT   5
`define FLAG_ENERGY  4
`define FLAG_MASK    16'h7FB0

// pattern test control fields
`define T_CHK_INV    7
`define T_GEN_INV    6
`define T_LOCK       5
`define T_CLR        4
`define T_PAT_HI     3
`define T_PAT_LO     2
`define T_CHK_EN     1
`define T_GEN_EN     0
`define TEST_MASK    16'hFFFF

// fiber control two fields
`define C2_FORCE     15
`define C2_NOISE     14
`define C2_FAR_FAULT 9
`define CTRL2_MASK   16'hFF80

// soft reset command bit
`define SOFT_GO      0

// pattern taps, as distance back minus one
`define TAP7_A       6
`define TAP7_B       5
`define TAP23_A      22
`define TAP23_B      17
`define TAP31_A      30
`define TAP31_B      27

// misc values
`define LOCK_RUN     6'h20
`define LFSR_SEED    31'h7FFFFFFF
`define RESP_OKAY    2'h0
`define RESP_SLVERR  2'h2
`define REG_ZERO     16'h0000

`endif

/* File: src/fiber_regs_pkg.sv */
// types for the fiber event and pattern test register block
// assumes the defines header supplies all numeric constants
package fiber_regs_pkg;

  typedef enum logic [1:0] {
    WR_IDLE     = 2'b00,
    WR_GOT_ADDR = 2'b01,
    WR_GOT_DATA = 2'b10,
    WR_RESP     = 2'b11
  } wr_state_t;

  typedef enum logic [1:0] {
    PAT_PRBS7  = 2'b00,
    PAT_PRBS23 = 2'b01,
    PAT_PRBS31 = 2'b10,
    PAT_ALT    = 2'b11
  } pattern_t;

  typedef struct packed {
    wr_state_t   wr;
    logic [5:0]  wr_index;
    logic [15:0] wr_data;
    logic [1:0]  wr_strb;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [15:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] flags;
    logic [15:0] enable;
    logic [15:0] test_ctrl;
    logic [15:0] ctrl_two;
    logic [31:0] err_count;
    logic [15:0] high_snap;
    logic [1:0]  prev_speed;
    logic        prev_duplex;
    logic        prev_link;
    logic [1:0]  prev_fault;
    logic        prev_energy;
    logic        primed;
    logic [30:0] gen_lfsr;
    logic        gen_bit;
    logic [30:0] chk_hist;
    logic [5:0]  good_run;
    logic        locked;
    logic        irq_n;
  } state_t;

endpackage

/* File: src/fiber_irq_status_prbs_regs.sv */
// fiber event flags, interrupt enables and pattern test registers
// assumes event inputs come from logic on core_clk, one bit per clock
// How it works
// RULE1: speed change sets flag bit 14
// RULE2: duplex change sets flag bit 13
// RULE3: received page sets flag bit 12
// RULE4: negotiation done sets flag bit 11
// RULE5: link up or down sets bit 10
// RULE6: symbol error bit 9, false carrier 8
// RULE7: elastic fifo over or underflow sets 7
// RULE8: remote fault code change sets bit 5
// RULE9: energy detect change sets bit 4
// RULE10: flags hold until read, live events persist; here a soft reset also clears them
// RULE11: per-bit enables gate flags onto interrupt
// RULE12: bit 7 inverts checker, 6 generator
// RULE13: lock bit delays counting until checker locks
// RULE14: count cleared only by clear bit
// RULE15: clear bit returns to zero itself
// RULE16: bits 3:2 pick prbs7/23/31 or alternating
// RULE17: checker and generator enables, soft reset clears
// RULE18: low half read captures upper half
// RULE19: software reads low half before high
// RULE20: force bit asserts interrupt output regardless
//
// Local design decision: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "fiber_regs_defines.svh"

module fiber_irq_status_prbs_regs
  import fiber_regs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  speed_code,
  input  wire logic        duplex_full,
  input  wire logic        page_received,
  input  wire logic        an_complete,
  input  wire logic        link_up,
  input  wire logic        symbol_error,
  input  wire logic        false_carrier,
  input  wire logic        elastic_fifo_error,
  input  wire logic [1:0]  remote_fault,
  input  wire logic        energy_present,
  input  wire logic        prbs_rx_bit,
  output logic             prbs_tx_bit,
  output logic             noise_filter_en,
  output logic             far_end_fault_indication_en,
  output logic             interrupt_out_n
);

  state_t      st;
  state_t      next_st;
  logic        aw_fire;
  logic        w_fire;
  logic        rd_fire;
  logic        wr_go;
  logic        wr_hit;
  logic        rd_hit;
  logic        soft_go;
  logic        flag_read;
  logic        chk_en;
  logic        gen_en;
  logic        rx_bit;
  logic        pred_rx;
  logic        pred_tx;
  logic        chk_err;
  logic        cnt_run;
  logic [5:0]  wr_idx;
  logic [5:0]  rd_idx;
  logic [15:0] wr_val;
  logic [1:0]  wr_be;
  logic [15:0] rd_val;
  logic [15:0] ev;
  pattern_t    mode;

  // next bit of the selected pattern from its own history
  function automatic logic pattern_next(input pattern_t pm,
                                        input logic [30:0] h);
    case (pm)
      PAT_PRBS7:  pattern_next = h[`TAP7_A] ^ h[`TAP7_B];
      PAT_PRBS23: pattern_next = h[`TAP23_A] ^ h[`TAP23_B];
      PAT_PRBS31: pattern_next = h[`TAP31_A] ^ h[`TAP31_B];
      default:    pattern_next = ~h[0];
    endcase
  endfunction

  // byte-lane merge of a write into a 16-bit register
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] nw,
                                        input logic [1:0]  be,
                                        input logic [15:0] mask);
    logic [15:0] m;
    m = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~m) | (nw & m);
  endfunction

  // bus handshakes, combinational from state
  assign s_axi_awready = (st.wr == WR_IDLE) || (st.wr == WR_GOT_DATA);
  assign s_axi_wready  = (st.wr == WR_IDLE) || (st.wr == WR_GOT_ADDR);
  assign s_axi_arready = !st.rvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_idx        = s_axi_araddr[7:2];

  // outputs straight from registers
  assign s_axi_bvalid  = (st.wr == WR_RESP);
  assign s_axi_bresp   = st.bresp;
  assign s_axi_rvalid  = st.rvalid;
  assign s_axi_rdata   = {`REG_ZERO, st.rdata};
  assign s_axi_rresp   = st.rresp;
  assign prbs_tx_bit   = st.gen_bit;
  assign noise_filter_en             = st.ctrl_two[`C2_NOISE];
  assign far_end_fault_indication_en = st.ctrl_two[`C2_FAR_FAULT];
  assign interrupt_out_n             = st.irq_n;

  // all next-state logic
  always_comb begin
    next_st = st;
    soft_go = 1'b0;
    wr_hit  = 1'b1;
    rd_hit  = 1'b1;
    rd_val  = `REG_ZERO;

    // write channel: address and data in either order
    wr_idx = (st.wr == WR_GOT_ADDR) ? st.wr_index : s_axi_awaddr[7:2];
    wr_val = (st.wr == WR_GOT_DATA) ? st.wr_data : s_axi_wdata[15:0];
    wr_be  = (st.wr == WR_GOT_DATA) ? st.wr_strb : s_axi_wstrb[1:0];
    wr_go  = (aw_fire || st.wr == WR_GOT_ADDR)
          && (w_fire || st.wr == WR_GOT_DATA);
    case (st.wr)
      WR_IDLE: begin
        if (wr_go) begin
          next_st.wr = WR_RESP;
        end else if (aw_fire) begin
          next_st.wr       = WR_GOT_ADDR;
          next_st.wr_index = s_axi_awaddr[7:2];
        end else if (w_fire) begin
          next_st.wr      = WR_GOT_DATA;
          next_st.wr_data = s_axi_wdata[15:0];
          next_st.wr_strb = s_axi_wstrb[1:0];
        end
      end
      WR_GOT_ADDR, WR_GOT_DATA: begin
        if (wr_go) begin
          next_st.wr = WR_RESP;
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          next_st.wr = WR_IDLE;
        end
      end
      default: next_st.wr = WR_IDLE;
    endcase

    // clear bit acts for one cycle then drops
    next_st.test_ctrl[`T_CLR] = 1'b0; // RULE15

    // register writes
    if (wr_go) begin
      case (wr_idx)
        `IDX_ENABLE: next_st.enable =
          merge(st.enable, wr_val, wr_be, `FLAG_MASK); // RULE11
        `IDX_FLAGS, `IDX_CNT_LO, `IDX_CNT_HI: wr_hit = 1'b1;
        `IDX_TEST: next_st.test_ctrl =
          merge(next_st.test_ctrl, wr_val, wr_be, `TEST_MASK);
        `IDX_CTRL2: next_st.ctrl_two =
          merge(st.ctrl_two, wr_val, wr_be, `CTRL2_MASK);
        `IDX_SOFT: soft_go = wr_val[`SOFT_GO] && wr_be[0];
        default: wr_hit = 1'b0;
      endcase
      next_st.bresp = wr_hit ? `RESP_OKAY : `RESP_SLVERR;
    end

    // soft reset drops both enables, the clear bit and one enable
    if (soft_go) begin
      next_st.test_ctrl[`T_CHK_EN] = 1'b0; // RULE17
      next_st.test_ctrl[`T_GEN_EN] = 1'b0; // RULE17
      next_st.test_ctrl[`T_CLR]    = 1'b0;
      next_st.enable[`FLAG_FAULT]  = 1'b0;
    end

    // read channel, answer one cycle after the address is taken
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    case (rd_idx)
      `IDX_ENABLE: rd_val = st.enable;
      `IDX_FLAGS:  rd_val = st.flags;
      `IDX_TEST:   rd_val = st.test_ctrl;
      `IDX_CNT_LO: rd_val = st.err_count[15:0];
      `IDX_CNT_HI: rd_val = st.high_snap;
      `IDX_CTRL2:  rd_val = st.ctrl_two;
      `IDX_SOFT:   rd_val = `REG_ZERO;
      default:     rd_hit = 1'b0;
    endcase
    if (rd_fire) begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_val;
      next_st.rresp  = rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end
    flag_read = rd_fire && (rd_idx == `IDX_FLAGS);

    // low half read freezes the upper half for the next read
    if (rd_fire && rd_idx == `IDX_CNT_LO) begin
      next_st.high_snap = st.err_count[31:16]; // RULE18
    end

    // change detection; first cycle after reset only primes
    ev = `REG_ZERO;
    if (st.primed) begin
      ev[`FLAG_SPEED]  = speed_code != st.prev_speed; // RULE1
      ev[`FLAG_DUPLEX] = duplex_full != st.prev_duplex; // RULE2
      ev[`FLAG_LINK]   = link_up != st.prev_link; // RULE5
      ev[`FLAG_FAULT]  = remote_fault != st.prev_fault; // RULE8
      ev[`FLAG_ENERGY] = energy_present != st.prev_energy; // RULE9
    end
    ev[`FLAG_PAGE]   = page_received; // RULE3
    ev[`FLAG_AN]     = an_complete; // RULE4
    ev[`FLAG_SYMBOL] = symbol_error; // RULE6
    ev[`FLAG_FALSE]  = false_carrier; // RULE6
    ev[`FLAG_FIFO]   = elastic_fifo_error; // RULE7
    next_st.primed      = 1'b1;
    next_st.prev_speed  = speed_code;
    next_st.prev_duplex = duplex_full;
    next_st.prev_link   = link_up;
    next_st.prev_fault  = remote_fault;
    next_st.prev_energy = energy_present;

    // sticky flags: a read clears, a live event wins over the clear
    next_st.flags = (((flag_read || soft_go) ? `REG_ZERO : st.flags)
                  | ev) & `FLAG_MASK; // RULE10

    // interrupt: forced, or any enabled flag
    next_st.irq_n = !(st.ctrl_two[`C2_FORCE] // RULE20
                   || |(st.flags & st.enable)); // RULE11

    // pattern generator
    mode    = pattern_t'(st.test_ctrl[`T_PAT_HI:`T_PAT_LO]); // RULE16
    gen_en  = st.test_ctrl[`T_GEN_EN];
    pred_tx = pattern_next(mode, st.gen_lfsr);
    if (gen_en) begin
      next_st.gen_lfsr = {st.gen_lfsr[29:0], pred_tx};
    end
    next_st.gen_bit = gen_en && (pred_tx ^ st.test_ctrl[`T_GEN_INV]); // RULE12

    // pattern checker, self-synchronising on received history
    chk_en  = st.test_ctrl[`T_CHK_EN];
    rx_bit  = prbs_rx_bit ^ st.test_ctrl[`T_CHK_INV]; // RULE12
    pred_rx = pattern_next(mode, st.chk_hist);
    chk_err = chk_en && (rx_bit != pred_rx);
    next_st.chk_hist = {st.chk_hist[29:0], rx_bit};
    if (!chk_en) begin
      next_st.good_run = 6'h00;
      next_st.locked   = 1'b0;
    end else if (chk_err) begin
      next_st.good_run = 6'h00;
    end else if (st.good_run == `LOCK_RUN) begin
      next_st.locked = 1'b1;
    end else begin
      next_st.good_run = st.good_run + 6'h01;
    end

    // error counter, gated by lock when asked
    cnt_run = !st.test_ctrl[`T_LOCK] || st.locked; // RULE13
    if (st.test_ctrl[`T_CLR]) begin
      next_st.err_count = 32'h00000000; // RULE14
      next_st.high_snap = `REG_ZERO; // RULE14
    end else if (chk_err && cnt_run) begin
      next_st.err_count = st.err_count + 32'h00000001;
    end
  end

  // the one state register
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st          <= '0;
      st.irq_n    <= 1'b1;
      st.gen_lfsr <= `LFSR_SEED;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_speed_flag: assert property ( // RULE1
    (st.primed && speed_code != st.prev_speed) |=> st.flags[`FLAG_SPEED])
    else $error("speed change not flagged");

  a_duplex_flag: assert property ( // RULE2
    (st.primed && duplex_full != st.prev_duplex)
      |=> st.flags[`FLAG_DUPLEX])
    else $error("duplex change not flagged");

  a_page_flag: assert property ( // RULE3
    page_received |=> st.flags[`FLAG_PAGE] ##1 1'b1)
    else $error("page receipt not flagged");

  a_energy_flag: assert property ( // RULE9
    (st.primed && energy_present != st.prev_energy)
      |=> st.flags[`FLAG_ENERGY])
    else $error("energy change not flagged");

  a_flag_hold: assert property ( // RULE10
    (st.flags[`FLAG_LINK] && !flag_read && !soft_go)
      |=> st.flags[`FLAG_LINK])
    else $error("link flag dropped without read");

  a_read_clear: assert property ( // RULE10
    (flag_read && !symbol_error) |=> !st.flags[`FLAG_SYMBOL])
    else $error("symbol flag survived read");

  a_irq_enabled: assert property ( // RULE11
    (|(st.flags & st.enable)) |=> !interrupt_out_n)
    else $error("enabled flag did not raise interrupt");

  a_irq_idle: assert property ( // RULE11
    (!st.ctrl_two[`C2_FORCE] && !(|(st.flags & st.enable)))
      |=> interrupt_out_n)
    else $error("interrupt without cause");

  a_force_irq: assert property ( // RULE20
    st.ctrl_two[`C2_FORCE] [*2] |-> !interrupt_out_n)
    else $error("forced interrupt not asserted");

  a_count_clear: assert property ( // RULE14
    st.test_ctrl[`T_CLR]
      |=> (st.err_count == 32'h00000000) && !st.test_ctrl[`T_CLR])
    else $error("count clear or self clear failed");

  a_lock_gate: assert property ( // RULE13
    (st.test_ctrl[`T_LOCK] && !st.locked && !st.test_ctrl[`T_CLR])
      |=> $stable(st.err_count))
    else $error("count moved before lock");

  a_snap_take: assert property ( // RULE18
    (rd_fire && rd_idx == `IDX_CNT_LO && !st.test_ctrl[`T_CLR])
      |=> st.high_snap == $past(st.err_count[31:16]))
    else $error("upper half not captured");

  a_alt_pattern: assert property ( // RULE16
    (gen_en && mode == PAT_ALT && !soft_go && !wr_go) [*3]
      |-> prbs_tx_bit != $past(prbs_tx_bit))
    else $error("alternating pattern did not toggle");

  a_gen_off: assert property ( // RULE17
    !gen_en |=> !prbs_tx_bit)
    else $error("generator output while disabled");

  a_link_flag: assert property ( // RULE5
    (st.primed && link_up != st.prev_link) |=> st.flags[`FLAG_LINK])
    else $error("link change not flagged");

  a_done_flag: assert property ( // RULE4
    an_complete |=> st.flags[`FLAG_AN])
    else $error("negotiation done not flagged");

  a_carrier_flag: assert property ( // RULE6
    false_carrier |=> st.flags[`FLAG_FALSE])
    else $error("false carrier not flagged");

  a_fifo_flag: assert property ( // RULE7
    elastic_fifo_error |=> st.flags[`FLAG_FIFO])
    else $error("fifo error not flagged");

  a_fault_flag: assert property ( // RULE8
    (st.primed && remote_fault != st.prev_fault)
      |=> st.flags[`FLAG_FAULT])
    else $error("remote fault change not flagged");

endmodule // fiber_irq_status_prbs_regs

/* File: test/link_partner_model.sv */
// far side model: fiber status sources and a serial pattern loopback
// assumes tasks are called just after a rising edge of core_clk
`timescale 1ns/1ps

module link_partner_model (
  input  wire logic       core_clk,
  input  wire logic       prbs_tx_bit,
  output logic [1:0]      speed_code,
  output logic            duplex_full,
  output logic            page_received,
  output logic            an_complete,
  output logic            link_up,
  output logic            symbol_error,
  output logic            false_carrier,
  output logic            elastic_fifo_error,
  output logic [1:0]      remote_fault,
  output logic            energy_present,
  output logic            prbs_rx_bit
);
  // quiet link at time zero
  initial begin
    {speed_code, duplex_full, link_up, remote_fault, energy_present} = 7'h00;
    {page_received, an_complete, symbol_error} = 3'h0;
    {false_carrier, elastic_fifo_error} = 2'h0;
  end

  // received line carries the generated pattern back unchanged
  assign prbs_rx_bit = prbs_tx_bit;

  // flip every level and strobe every event for one cycle
  task automatic fire_all();
    {speed_code, duplex_full, link_up, remote_fault, energy_present} <=
      ~{speed_code, duplex_full, link_up, remote_fault, energy_present};
    {page_received, an_complete, symbol_error} <= 3'h7;
    {false_carrier, elastic_fifo_error} <= 2'h3;
    @(posedge core_clk);
    {page_received, an_complete, symbol_error} <= 3'h0;
    {false_carrier, elastic_fifo_error} <= 2'h0;
  endtask

  // single link transition
  task automatic toggle_link();
    link_up <= ~link_up;
  endtask

  // symbol error held as a level
  task automatic hold_symbol(input logic v);
    symbol_error <= v;
  endtask
endmodule // link_partner_model

/* File: test/tb.sv */
// bench for the fiber event and pattern test registers over axi4-lite
// assumes the link partner model loops the pattern back
`timescale 1ns/1ps

module tb;
  logic        core_clk, sys_rst, prbs_rx_bit, prbs_tx_bit;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, speed_code, remote_fault;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, duplex_full, page_received;
  logic        an_complete, link_up, symbol_error, false_carrier;
  logic        elastic_fifo_error, energy_present, noise_filter_en;
  logic        far_end_fault_indication_en, interrupt_out_n;
  logic [15:0] v, x;
  logic [1:0]  rs;
  int          bad_count, check_count;

  fiber_irq_status_prbs_regs DUT (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .speed_code(speed_code),
    .duplex_full(duplex_full), .page_received(page_received),
    .an_complete(an_complete), .link_up(link_up),
    .symbol_error(symbol_error), .false_carrier(false_carrier),
    .elastic_fifo_error(elastic_fifo_error), .remote_fault(remote_fault),
    .energy_present(energy_present), .prbs_rx_bit(prbs_rx_bit),
    .prbs_tx_bit(prbs_tx_bit), .noise_filter_en(noise_filter_en),
    .far_end_fault_indication_en(far_end_fault_indication_en),
    .interrupt_out_n(interrupt_out_n)
  );
  link_partner_model lp (
    .core_clk(core_clk), .prbs_tx_bit(prbs_tx_bit),
    .speed_code(speed_code), .duplex_full(duplex_full),
    .page_received(page_received), .an_complete(an_complete),
    .link_up(link_up), .symbol_error(symbol_error),
    .false_carrier(false_carrier), .elastic_fifo_error(elastic_fifo_error),
    .remote_fault(remote_fault), .energy_present(energy_present),
    .prbs_rx_bit(prbs_rx_bit)
  );

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  task automatic check(input string what, input logic [15:0] e,
                       input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask

  // write one word, valids dropped as each channel is taken
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    int n;
    logic ta, tw, done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done && n < 50) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      done = (s_axi_bvalid === 1'b1);
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    check("write resp", 16'h0000, done ? {14'h0, rs} : 16'hFFFF);
  endtask

  // read one word into v and rs
  task automatic rd(input logic [7:0] a);
    int n;
    logic ta, done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done && n < 50) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      done = (s_axi_rvalid === 1'b1);
      v = s_axi_rdata[15:0];
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    if (!done) rs = 2'h3;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [15:0] e);
    rd(a);
    check($sformatf("reg %h", a), e, v);
    check("read resp", 16'h0000, {14'h0, rs});
  endtask

  // interrupt pin two edges after its cause
  task automatic pin(input logic e);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    check("interrupt_out_n", {15'h0, e}, {15'h0, interrupt_out_n});
    @(posedge core_clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // watchdog well beyond the expected run
  initial begin
    #(50 * 20000);
    bad_count++;
    $display("[FAIL] watchdog expired");
    results();
  end

  initial begin
    sys_rst = 1'b1;
    // response readies stay high for the whole run
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h1;
    {s_axi_arvalid, s_axi_rready} = 2'h1;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    // reset values and an unmapped place
    rchk(8'h4C, 16'h0000);
    rchk(8'h5C, 16'h0000);
    rchk(8'h60, 16'h0000);
    rchk(8'h64, 16'h0000);
    rchk(8'h68, 16'h0000);
    rd(8'h00);
    check("unmapped resp", 16'h0002, {14'h0, rs});
    // every event at once, interrupt masked
    lp.fire_all();
    pin(1'b1);
    rd(8'h4C);
    check("all flags", 16'h7FB0, v);
    check("read resp", 16'h0000, {14'h0, rs});
    rchk(8'h4C, 16'h0000);
    // enabled link change drives the pin, read releases it
    wr(8'h48, 16'h7FB0);
    lp.toggle_link();
    pin(1'b0);
    rchk(8'h4C, 16'h0400);
    pin(1'b1);
    // persistent event survives the clearing read
    lp.hold_symbol(1'b1);
    repeat (2) @(posedge core_clk);
    rchk(8'h4C, 16'h0200);
    rchk(8'h4C, 16'h0200);
    lp.hold_symbol(1'b0);
    rchk(8'h4C, 16'h0200);
    rchk(8'h4C, 16'h0000);
    // forced interrupt and control outputs
    wr(8'h68, 16'hC200);
    pin(1'b0);
    check("ctrl outs", 16'h0003,
          {14'h0, noise_filter_en, far_end_fault_indication_en});
    rchk(8'h68, 16'hC200);
    wr(8'h68, 16'h0000);
    pin(1'b1);
    // every pattern looped back runs clean after a clear
    for (int p = 0; p < 4; p++) begin
      wr(8'h5C, 16'h0003 | (p << 2));
      repeat (100) @(posedge core_clk);
      wr(8'h5C, 16'h0013 | (p << 2));
      repeat (100) @(posedge core_clk);
      rchk(8'h5C, 16'h0003 | (p << 2));
      rchk(8'h60, 16'h0000);
      rchk(8'h64, 16'h0000);
    end
    // inverted checker only: free-running count of errors
    wr(8'h5C, 16'h008B);
    repeat (100) @(posedge core_clk);
    rd(8'h60);
    check("errors seen", 16'h0001, {15'h0, v != 16'h0000});
    // stopped count survives writes without the clear bit
    wr(8'h5C, 16'h0088);
    rd(8'h60);
    x = v;
    wr(8'h5C, 16'h0088);
    rchk(8'h60, x);
    rchk(8'h64, 16'h0000);
    // both sides inverted cancel out
    wr(8'h5C, 16'h00CB);
    repeat (100) @(posedge core_clk);
    wr(8'h5C, 16'h00DB);
    repeat (100) @(posedge core_clk);
    rchk(8'h60, 16'h0000);
    // soft reset drops the checker and generator enables and keeps the other test bits
    wr(8'h7C, 16'h0001);
    rchk(8'h5C, 16'h00C8);
    // lock gating: checker never locks, so nothing counts
    wr(8'h5C, 16'h00AB);
    wr(8'h5C, 16'h00BB);
    repeat (200) @(posedge core_clk);
    rchk(8'h60, 16'h0000);
    results();
  end
endmodule // tb
